/* logic/sam_pkg.sv */
package sam_pkg;

  localparam int ADDR_W = 27;
  localparam int PIN_W = 18;
  localparam int DATA_W = 32;

  // Configuration encodings
  localparam logic [1:0] BUS_32 = 2'h3;
  localparam logic [1:0] BUS_16 = 2'h2;
  localparam logic [1:0] ROW_11 = 2'h0;
  localparam logic [1:0] ROW_12 = 2'h1;
  localparam logic [1:0] COL_8 = 2'h0;
  localparam logic [1:0] COL_9 = 2'h1;

  // Row cycle shift per configuration
  localparam int ROW_SHIFT_A = 8;
  localparam int ROW_SHIFT_B = 9;

  // Precharge pin and bank pins
  localparam int AP_PIN_A = 12;
  localparam int AP_PIN_B = 11;
  localparam int BA1_PIN = 14;
  localparam int BA0_PIN = 13;
  localparam int BA1_SRC_A = 22;
  localparam int BA0_SRC_A = 21;
  localparam int BA1_SRC_B = 23;
  localparam int BA0_SRC_B = 22;

  // Register map, word aligned byte addresses
  localparam logic [3:0] OFF_CFG = 4'h0;
  localparam logic [3:0] OFF_ADDR = 4'h4;
  localparam logic [3:0] OFF_CTRL = 4'h8;
  localparam logic [3:0] OFF_STAT = 4'hc;

  // Config register fields
  localparam int CFG_BUS_LSB = 0;
  localparam int CFG_ROW_LSB = 2;
  localparam int CFG_COL_LSB = 4;
  localparam logic [5:0] CFG_RST = 6'h03;

  // Control register fields
  localparam int CTRL_PHASE_BIT = 0;
  localparam int CTRL_AP_BIT = 1;

  typedef enum logic {SAM_ROW, SAM_COL} sam_phase_t;

  typedef struct packed {
    logic [1:0] col_width_select;
    logic [1:0] row_width_select;
    logic [1:0] bus_width_select;
  } sam_cfg_t;

endpackage : sam_pkg

/* logic/sam_addr_mux.sv */
// The placing of the registers and register access over Avalon-MM were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module sam_addr_mux (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic [17:0] sdram_addr_o,
  output logic [1:0] cfg_valid_o
);

  sam_pkg::sam_cfg_t cfg_reg;
  logic [sam_pkg::ADDR_W-1:0] addr_reg;
  logic phase_reg;
  logic ap_reg;
  logic ack_reg;
  logic [31:0] rdata_reg;
  logic [17:0] pin_reg;
  logic [1:0] valid_reg;

  wire req = (avs_read_i | avs_write_i) & ~ack_reg;
  // Writes land only at the edge where waitrequest is seen low by the master
  wire wr = avs_write_i & ack_reg;
  wire sel_cfg = avs_address_i == sam_pkg::OFF_CFG;
  wire sel_addr = avs_address_i == sam_pkg::OFF_ADDR;
  wire sel_ctrl = avs_address_i == sam_pkg::OFF_CTRL;
  wire sel_stat = avs_address_i == sam_pkg::OFF_STAT;

  wire mode_a = cfg_reg.bus_width_select == sam_pkg::BUS_32 &&
    cfg_reg.row_width_select == sam_pkg::ROW_11 && cfg_reg.col_width_select == sam_pkg::COL_8;
  wire mode_b = cfg_reg.bus_width_select == sam_pkg::BUS_16 &&
    cfg_reg.row_width_select == sam_pkg::ROW_12 && cfg_reg.col_width_select == sam_pkg::COL_9;

  wire [17:0] row_a = addr_reg[sam_pkg::ROW_SHIFT_A +: sam_pkg::PIN_W];
  wire [17:0] row_b = addr_reg[sam_pkg::ROW_SHIFT_B +: sam_pkg::PIN_W];

  logic [17:0] col_a;
  logic [17:0] col_b;
  logic [17:0] pin_next;

  always_comb begin
    col_a = addr_reg[sam_pkg::PIN_W-1:0];
    // Bank and command pins, mode A
    col_a[sam_pkg::BA1_PIN] = addr_reg[sam_pkg::BA1_SRC_A];
    col_a[sam_pkg::BA0_PIN] = addr_reg[sam_pkg::BA0_SRC_A];
    col_a[sam_pkg::AP_PIN_A] = ap_reg;
    col_b = addr_reg[sam_pkg::PIN_W-1:0];
    // Bank and command pins, mode B
    col_b[sam_pkg::BA1_PIN] = addr_reg[sam_pkg::BA1_SRC_B];
    col_b[sam_pkg::BA0_PIN] = addr_reg[sam_pkg::BA0_SRC_B];
    col_b[sam_pkg::AP_PIN_B] = ap_reg;
  end

  // Combinational selection; unsupported settings drive zero
  // Row and column windows both put the same bank bits on pins 14,13
  always_comb begin
    pin_next = '0;
    if (mode_a) begin
      pin_next = (phase_reg == sam_pkg::SAM_COL) ? col_a : row_a;
    end else if (mode_b) begin
      pin_next = (phase_reg == sam_pkg::SAM_COL) ? col_b : row_b;
    end
  end

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0;
    if (sel_cfg) begin
      rd_mux[5:0] = cfg_reg;
    end else if (sel_addr) begin
      rd_mux[sam_pkg::ADDR_W-1:0] = addr_reg;
    end else if (sel_ctrl) begin
      rd_mux[sam_pkg::CTRL_PHASE_BIT] = phase_reg;
      rd_mux[sam_pkg::CTRL_AP_BIT] = ap_reg;
    end else if (sel_stat) begin
      rd_mux[17:0] = pin_reg;
      rd_mux[19:18] = valid_reg;
    end
  end

  // One wait state: each access is answered on the edge after it is seen
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h0;
    end else begin
      ack_reg <= req;
      rdata_reg <= rd_mux;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cfg_reg <= sam_pkg::CFG_RST;
      addr_reg <= '0;
      phase_reg <= sam_pkg::SAM_ROW;
      ap_reg <= 1'b0;
    end else if (wr && sel_cfg) begin
      cfg_reg <= avs_writedata_i[5:0];
    end else if (wr && sel_addr) begin
      addr_reg <= avs_writedata_i[sam_pkg::ADDR_W-1:0];
    end else if (wr && sel_ctrl) begin
      phase_reg <= avs_writedata_i[sam_pkg::CTRL_PHASE_BIT];
      ap_reg <= avs_writedata_i[sam_pkg::CTRL_AP_BIT];
    end
  end

  // Pins registered so they stand still for the whole cycle
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_reg <= '0;
      valid_reg <= 2'h0;
    end else begin
      pin_reg <= pin_next;
      // Bit 0 flags mode A, bit 1 mode B
      valid_reg <= {mode_b, mode_a};
    end
  end

  assign avs_readdata_o = rdata_reg;
  assign avs_waitrequest_o = ~ack_reg;
  assign sdram_addr_o = pin_reg;
  assign cfg_valid_o = valid_reg;

endmodule : sam_addr_mux
`default_nettype wire

/* verif/sam_addr_mux_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module sam_addr_mux_sva (
  input wire logic sys_clk_i, rst_i, avs_read_i, avs_write_i, avs_waitrequest_o,
  input wire logic [3:0] avs_address_i,
  input wire logic [31:0] avs_writedata_i, avs_readdata_o,
  input wire logic [17:0] sdram_addr_o,
  input wire logic [1:0] cfg_valid_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  wire logic ack = !avs_waitrequest_o;
  wire logic cw = ack && avs_write_i && avs_address_i == 4'h8 && avs_writedata_i[0];
  wire logic [17:0] p = sdram_addr_o;
  AST_WAIT: assert property ((avs_read_i || avs_write_i) && !ack |=> ack) else $error("no ack");
  AST_PULSE: assert property (ack |=> !ack) else $error("long ack");
  AST_MODE: assert property ($onehot0(cfg_valid_o)) else $error("two modes");
  AST_OFF: assert property (cfg_valid_o == 2'h0 |-> p == 18'h0) else $error("pins");
  AST_HOLD: assert property (!$past(avs_write_i) && !$past(avs_write_i, 2) |-> $stable(p))
    else $error("pins moved");
  AST_UNMAP: assert property (ack && avs_read_i && avs_address_i[1:0] != 2'h0
    |-> avs_readdata_o == 32'h0) else $error("unmapped");
  AST_BANK: assert property (cw |=> $stable(p[14:13]) [*2]) else $error("bank moved");
  // Precharge pin sits at 12 in mode A, 11 in mode B
  AST_AP: assert property (cw && cfg_valid_o != 2'h0 |=> ##1
    p[cfg_valid_o[0] ? 12 : 11] == $past(avs_writedata_i[1], 2)) else $error("ap");
  cover property (cw && cfg_valid_o[0]);
  cover property (cw && cfg_valid_o[1]);
  cover property (ack && avs_read_i && avs_address_i == 4'hc);
endmodule : sam_addr_mux_sva
bind sam_addr_mux sam_addr_mux_sva i_sva (.*);
`default_nettype wire

/* verif/sam_sdram_model.sv */
`timescale 1ns/1ps
`default_nettype none
module sam_sdram_model (
  input wire logic sys_clk_i,
  input wire logic [17:0] addr_i
);
  logic [1:0] bank_reg;
  always_ff @(posedge sys_clk_i) bank_reg <= addr_i[14:13];
endmodule : sam_sdram_model
`default_nettype wire

/* verif/sam_addr_mux_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module sam_addr_mux_tb_top;
  logic sys_clk_i = 0, rst_i = 1, avs_read_i = 0, avs_write_i = 0, avs_waitrequest_o;
  logic [3:0] avs_address_i = 4'h0;
  logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, q[$];
  logic [17:0] sdram_addr_o;
  logic [1:0] cfg_valid_o;
  int error_cnt = 0, n_checks = 0, cyc = 0;
  sam_addr_mux i_dut (.*);
  sam_sdram_model i_mem (.sys_clk_i, .addr_i(sdram_addr_o));
  initial forever #2 sys_clk_i = ~sys_clk_i;
  task automatic chk(input logic [31:0] s, e);
    n_checks++;
    if (s !== e) begin error_cnt++; $display("BAD %0t %h %h", $time, s, e); end
  endtask : chk
  task automatic print_verdict;
    $display("checks %0d bad %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= w;
    avs_read_i <= !w;
    do @(posedge sys_clk_i); while (avs_waitrequest_o !== 1'b0);
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    @(posedge sys_clk_i);
  endtask : bus
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask : rd
  function automatic logic [31:0] st(input logic b, input logic [1:0] c, input logic [26:0] a);
    logic [17:0] p;
    if (!c[0]) p = b ? a[26:9] : a[25:8];
    else if (b) p = {a[17:15], a[23:22], a[12], c[1], a[10:0]};
    else p = {a[17:15], a[22:21], c[1], a[11:0]};
    return {12'h0, b, !b, p};
  endfunction : st
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc > 3000) begin error_cnt++; print_verdict(); end
    else if (avs_read_i && avs_waitrequest_o === 1'b0 && q.size() > 0)
      chk(avs_readdata_o, q.pop_front());
  end
  initial begin
    logic [26:0] a;
    logic [1:0] c;
    void'($urandom(4));
    repeat (2) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    @(posedge sys_clk_i);
    rd(4'h0, 32'h3);
    rd(4'h6, 32'h0);
    for (int m = 0; m < 8; m++) begin
      a = 27'($urandom);
      c = 2'($urandom);
      bus(1'b1, 4'h0, m[2] ? 32'h16 : 32'h3);
      bus(1'b1, 4'h4, {5'h0, a});
      // Same address seen in both phases so bank lines can be compared
      for (int k = 0; k < 2; k++) begin
        bus(1'b1, 4'h8, {30'h0, c});
        rd(4'hc, st(m[2], c, a));
        chk({12'h0, cfg_valid_o, sdram_addr_o}, st(m[2], c, a));
        c[0] = !c[0];
      end
      $display("test %0d done", m);
    end
    bus(1'b1, 4'h0, 32'h0);
    rd(4'hc, 32'h0);
    print_verdict();
  end
endmodule : sam_addr_mux_tb_top
`default_nettype wire
